// ===== hda_arb.v
`timescale 1ns/1ps
`include "hda_map.vh"
module hda_arb #(
    parameter NCH = `HDA_NCH
) (
    input wire clk,
    input wire resetn,
    input wire [NCH-1:0] req,
    input wire [3*NCH-1:0] prio,
    input wire [NCH-1:0] no_rr,
    input wire fair_en,
    input wire take,
    output wire gnt_vld,
    output reg [4:0] gnt_idx
);
    reg [5:0] slot_r;
    reg [4:0] last_r [0:7];
    reg [7:0] has;
    reg [2:0] lvl;
    reg [2:0] fav;
    reg hit;
    integer c;
    integer k;
    integer j;

    assign gnt_vld = |req;

    // ****************************************************************
    // level choice, then channel choice inside the level
    // ****************************************************************
    always @* begin
        has = 8'h00;
        lvl = 3'h7;
        hit = 1'b0;
        gnt_idx = 5'h00;
        for (c = 0; c < NCH; c = c + 1) begin
            if (req[c]) begin
                has[prio[c*3 +: 3]] = 1'b1;
            end
        end
        for (k = 7; k >= 0; k = k - 1) begin
            if (has[k]) begin
                lvl = k[2:0];
            end
        end
        casez (slot_r)
            6'b?????1: fav = 3'h2;
            6'b????10: fav = 3'h3;
            6'b???100: fav = 3'h4;
            6'b??1000: fav = 3'h5;
            6'b?10000: fav = 3'h6;
            default: fav = 3'h7;
        endcase
        // slot pattern hands each level 2..7 its interleaved share
        if (fair_en && lvl >= `HDA_FAIR_LVL && has[fav]) begin
            lvl = fav;
        end
        for (c = NCH - 1; c >= 0; c = c - 1) begin
            if (req[c] && no_rr[c] && prio[c*3 +: 3] == lvl) begin
                gnt_idx = c[4:0];
                hit = 1'b1;
            end
        end
        for (c = NCH; c >= 1; c = c - 1) begin
            k = last_r[lvl] + c;
            if (k >= NCH) begin
                k = k - NCH;
            end
            if (!hit && req[k] && prio[k*3 +: 3] == lvl) begin
                gnt_idx = k[4:0];
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slot_r <= 6'h00;
            for (j = 0; j < 8; j = j + 1) begin
                last_r[j] <= 5'h00;
            end
        end else if (take) begin
            last_r[lvl] <= gnt_idx;
            if (lvl >= `HDA_FAIR_LVL) begin
                slot_r <= slot_r + 6'h01;
            end
        end
    end
endmodule

// ===== hda_checker.sv
`timescale 1ns/1ps
module hda_checker #(
    parameter NCH = 24
) (
    input wire clk,
    input wire resetn,
    input wire cpu_req,
    input wire [31:0] cpu_addr,
    input wire cpu_done_r,
    input wire [NCH-1:0] chn_irq0_r,
    input wire [NCH-1:0] chn_busy_r,
    input wire [7:0] spk_req,
    input wire [255:0] spk_addr,
    input wire [7:0] spk_ack
);
// ****
// port checks
// ****
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
sequence pool_acc;
    $rose(cpu_req) && !cpu_done_r && cpu_addr[26:11] == 16'h4000;
endsequence
sequence spk4_ack;
    cpu_req && !cpu_done_r && cpu_addr[26:24] == 3'h4 && spk_ack[4];
endsequence
pool_time_a: assert property (
    pool_acc |=> !cpu_done_r [*2] ##1 cpu_done_r)
    else $error("pool access answer time wrong");
spoke_done_a: assert property (spk4_ack |=> cpu_done_r)
    else $error("cpu done missing after spoke ack");
done_pulse_a: assert property (cpu_done_r |=> !cpu_done_r)
    else $error("cpu done longer than one cycle");
spk_hold_a: assert property (
    spk_req[1] && !spk_ack[1] |=> spk_req[1] && $stable(spk_addr[63:32]))
    else $error("spoke request not held");
spk_drop_a: assert property (spk_req[1] && spk_ack[1] |=> !spk_req[1])
    else $error("spoke request not dropped after ack");
irq_pulse_a: assert property (chn_irq0_r[0] |=> !chn_irq0_r[0])
    else $error("irq longer than one cycle");
busy_one_a: assert property ($onehot0(chn_busy_r))
    else $error("two channels busy");
reset_idle_a: assert property ($rose(resetn) |-> spk_req == 8'h00)
    else $error("spoke request right after reset");
endmodule

// ===== hda_map.vh
`ifndef HDA_MAP_VH
`define HDA_MAP_VH
// Notes on behaviour
// - eight spokes run in parallel; cpu and dma meet only on one spoke
// - dma source read and destination write overlap on different spokes
// - each access carries 8, 16, 24 or 32 bits
// - spokes: 0 sram, 1 io, 2 hub config, 3 analog, 4 usb, 6-7 logic
// - 24 channels share a pool of 128 transfer descriptors
// - descriptor pool is memory mapped on spoke 2, reachable by dma
// - each channel has priority 0 (highest) to 7 (lowest)
// - channel starts on hardware, cpu or other-channel completion trigger
// - each descriptor may pulse up to two interrupt lines per transfer
// - active channel can be stalled and resumed, or cancelled
// - descriptor length is 1 to 65535 bytes, or zero meaning endless
// - transfers are cut into bursts of 1 to 127 bytes
// - cpu wins any spoke it shares with the dma
// - higher priority waits until current descriptor finishes
// - with fairness, levels 2-6 get slots of 1/2, 1/4 ... 1/32, and level 7 also gets 1/32
// - levels 0 and 1 bypass fairness and may take all bandwidth
// - equal level requests share by round robin
// - channel can leave rotation and win ties at its level; among such channels the lowest index wins
// - without fairness grants go purely by priority level
// - descriptor linked to itself repeats forever
// - finished descriptor hands over to its linked descriptor
// - a descriptor may rewrite a later descriptor before it runs

// ****************************************************************
// sizes and address map
// ****************************************************************
`define HDA_NCH 24
`define HDA_NTD 128
`define HDA_TD_WORDS 512
`define HDA_SPK_MSB 26
`define HDA_SPK_LSB 24
`define HDA_TD_SPK 3'h2
`define HDA_WIN_MSB 23
`define HDA_WIN_LSB 11
`define HDA_TD_WIN 13'h0000
`define HDA_FAIR_LVL 3'h2

// ****************************************************************
// descriptor word 2 and word 3 fields
// ****************************************************************
`define HDA_W2_CNT_MSB 15
`define HDA_W2_BST_LSB 16
`define HDA_W2_NXT_LSB 23
`define HDA_W2_NXV 30
`define HDA_W3_IRQ0 0
`define HDA_W3_IRQ1 1
`define HDA_W3_SINC 2
`define HDA_W3_DINC 3
`define HDA_W3_SIZE_LSB 4
`endif

// ===== hda_spoke_model.sv
`timescale 1ns/1ps
module hda_spoke_model (
    input wire clk,
    input wire resetn,
    input wire slow,
    input wire [7:0] spk_req,
    input wire [255:0] spk_addr,
    output logic [255:0] spk_rdata,
    output logic [7:0] spk_ack
);
// ****
// eight independent spoke slaves
// ****
logic [1:0] wait_r [8];
always @(posedge clk or negedge resetn) begin
    for (int i = 0; i < 8; i++) begin
        if (!resetn) begin
            spk_ack[i] <= 1'h0;
            wait_r[i] <= 2'h0;
        end else begin
            spk_ack[i] <= 1'h0;
            if (spk_req[i] && !spk_ack[i]) begin
                wait_r[i] <= wait_r[i] + 2'h1;
                if (!slow || wait_r[i] == 2'h3) begin
                    spk_ack[i] <= 1'h1;
                    wait_r[i] <= 2'h0;
                end
            end
        end
    end
end
// idle lines carry the inverse, so stale data never passes
always_comb begin
    for (int i = 0; i < 8; i++) begin
        spk_rdata[i*32+:32] = spk_addr[i*32+:32] ^ 32'hA5A5_0000
            ^ {32{!spk_ack[i]}};
    end
end
endmodule

// ===== hda_tdram.v
`timescale 1ns/1ps
`include "hda_map.vh"
module hda_tdram #(
    parameter NW = `HDA_TD_WORDS,
    parameter AW = 9
) (
    input wire clk,
    input wire a_en,
    input wire a_we,
    input wire [1:0] a_size,
    input wire [AW-1:0] a_addr,
    input wire [31:0] a_wdata,
    output reg [31:0] a_rdata,
    input wire [AW-1:0] b_addr,
    output reg [31:0] b_rdata
);
    reg [31:0] mem [0:NW-1];
    integer i;

    // ****************************************************************
    // bus port writes low bytes by size, engine port only reads
    // ****************************************************************
    always @(posedge clk) begin
        if (a_en) begin
            a_rdata <= mem[a_addr];
            if (a_we) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (i <= a_size) begin
                        mem[a_addr][i*8 +: 8] <= a_wdata[i*8 +: 8];
                    end
                end
            end
        end
        b_rdata <= mem[b_addr];
    end
endmodule

// ===== hda_top.v
`timescale 1ns/1ps
`include "hda_map.vh"
module hda_top #(
    parameter NCH = `HDA_NCH
) (
    input wire clk,
    input wire resetn,
    input wire cpu_req,
    input wire cpu_we,
    input wire [31:0] cpu_addr,
    input wire [31:0] cpu_wdata,
    input wire [1:0] cpu_size,
    output reg [31:0] cpu_rdata_r,
    output reg cpu_done_r,
    input wire fair_en,
    input wire [3*NCH-1:0] chn_prio,
    input wire [7*NCH-1:0] chn_first_td,
    input wire [NCH-1:0] chn_no_rr,
    input wire [NCH-1:0] chn_hw_trig,
    input wire [NCH-1:0] chn_cpu_trig,
    input wire [NCH-1:0] chn_chain_en,
    input wire [5*NCH-1:0] chn_chain_sel,
    input wire [NCH-1:0] chn_stall,
    input wire [NCH-1:0] chn_cancel,
    output reg [NCH-1:0] chn_irq0_r,
    output reg [NCH-1:0] chn_irq1_r,
    output reg [NCH-1:0] chn_busy_r,
    output wire [7:0] spk_req,
    output wire [7:0] spk_we,
    output wire [255:0] spk_addr,
    output wire [255:0] spk_wdata,
    output wire [15:0] spk_size,
    input wire [255:0] spk_rdata,
    input wire [7:0] spk_ack
);
    localparam S_IDLE = 3'h0;
    localparam S_FETCH = 3'h1;
    localparam S_BST = 3'h2;
    localparam S_RUN = 3'h3;
    localparam S_END = 3'h4;
    localparam OWN_NONE = 2'h0;
    localparam OWN_CPU = 2'h1;
    localparam OWN_RD = 2'h2;
    localparam OWN_WR = 2'h3;
    localparam NT = 9;

    // ****************************************************************
    // shared decoding
    // ****************************************************************
    function [3:0] hda_tgt;
        input [31:0] a;
        begin
            if (a[`HDA_SPK_MSB:`HDA_SPK_LSB] == `HDA_TD_SPK &&
                a[`HDA_WIN_MSB:`HDA_WIN_LSB] == `HDA_TD_WIN) begin
                hda_tgt = 4'h8;
            end else begin
                hda_tgt = {1'b0, a[`HDA_SPK_MSB:`HDA_SPK_LSB]};
            end
        end
    endfunction

    function [2:0] hda_beat;
        input [1:0] sz;
        input [6:0] left;
        begin
            if ({5'h00, sz} + 7'h01 < left) begin
                hda_beat = {1'b0, sz} + 3'h1;
            end else begin
                hda_beat = left[2:0];
            end
        end
    endfunction

    reg [1:0] own_r [0:NT-1];
    reg [NT-1:0] t_req_r;
    reg [NT-1:0] t_we_r;
    reg [32*NT-1:0] t_addr_r;
    reg [32*NT-1:0] t_wdata_r;
    reg [2*NT-1:0] t_size_r;
    reg ram_ack_r;
    wire [31:0] ram_rdata;
    wire [31:0] b_rdata;
    wire [NT-1:0] t_ack;
    wire [32*NT-1:0] t_rdata;

    reg [2:0] st_r;
    reg [4:0] ch_r;
    reg [6:0] td_r;
    reg [2:0] f_r;
    reg [31:0] src_r;
    reg [31:0] dst_r;
    reg [15:0] rem_r;
    reg inf_r;
    reg [6:0] bst_r;
    reg [6:0] nxt_r;
    reg nxv_r;
    reg [5:0] fl_r;
    reg [6:0] rl_r;
    reg [6:0] wl_r;
    reg [6:0] cur_r;
    reg [31:0] rbuf_r;
    reg [2:0] rbn_r;
    reg rbv_r;
    reg [31:0] wbuf_r;
    reg [2:0] wbn_r;
    reg wbv_r;
    reg cx_r;
    reg [NCH-1:0] pend_r;
    reg [NCH-1:0] chain_r;
    reg [6:0] ctd_r [0:NCH-1];

    reg cpu_dn;
    reg rd_dn;
    reg wr_dn;
    reg dma_out;
    reg [31:0] cpu_rd;
    reg [31:0] rd_data;
    reg [NCH-1:0] trig;
    wire gnt_vld;
    wire [4:0] gnt_idx;
    integer t;
    integer c;
    integer m;
    integer g;

    assign t_ack = {ram_ack_r, spk_ack};
    assign t_rdata = {ram_rdata, spk_rdata};
    assign spk_req = t_req_r[7:0];
    assign spk_we = t_we_r[7:0];
    assign spk_addr = t_addr_r[255:0];
    assign spk_wdata = t_wdata_r[255:0];
    assign spk_size = t_size_r[15:0];

    wire [1:0] size = fl_r[`HDA_W3_SIZE_LSB +: 2];
    wire [2:0] rd_n = hda_beat(size, rl_r);
    wire stl = chn_stall[ch_r];
    wire cpu_go = cpu_req & ~cpu_done_r;
    wire rd_go = (st_r == S_RUN) && rl_r != 7'h00 && !rbv_r && !stl && !cx_r;
    wire wr_go = (st_r == S_RUN) && wbv_r && !stl && !cx_r;
    wire [3:0] cpu_t = hda_tgt(cpu_addr);
    wire [3:0] src_t = hda_tgt(src_r);
    wire [3:0] dst_t = hda_tgt(dst_r);
    wire fin_v = (st_r == S_END) && !cx_r && !nxv_r;

    // ****************************************************************
    // per-target owner, one access in flight on each target
    // ****************************************************************
    always @* begin
        cpu_dn = 1'b0;
        rd_dn = 1'b0;
        wr_dn = 1'b0;
        dma_out = 1'b0;
        cpu_rd = 32'h0000_0000;
        rd_data = 32'h0000_0000;
        for (m = 0; m < NT; m = m + 1) begin
            if (own_r[m] == OWN_RD || own_r[m] == OWN_WR) begin
                dma_out = 1'b1;
            end
            if (t_ack[m]) begin
                case (own_r[m])
                    OWN_CPU: begin
                        cpu_dn = 1'b1;
                        cpu_rd = t_rdata[m*32 +: 32];
                    end
                    OWN_RD: begin
                        rd_dn = 1'b1;
                        rd_data = t_rdata[m*32 +: 32];
                    end
                    OWN_WR: wr_dn = 1'b1;
                    default: ;
                endcase
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (t = 0; t < NT; t = t + 1) begin
                own_r[t] <= OWN_NONE;
            end
            t_req_r <= 9'h000;
            t_we_r <= 9'h000;
            t_addr_r <= {(32*NT){1'b0}};
            t_wdata_r <= {(32*NT){1'b0}};
            t_size_r <= 18'h00000;
            ram_ack_r <= 1'b0;
            cpu_done_r <= 1'b0;
            cpu_rdata_r <= 32'h0000_0000;
        end else begin
            // the internal pool answers one cycle after its request
            ram_ack_r <= t_req_r[8] & ~ram_ack_r;
            cpu_done_r <= cpu_dn;
            if (cpu_dn) begin
                cpu_rdata_r <= cpu_rd;
            end
            for (t = 0; t < NT; t = t + 1) begin
                if (own_r[t] == OWN_NONE) begin
                    if (cpu_go && cpu_t == t) begin
                        own_r[t] <= OWN_CPU;
                        t_req_r[t] <= 1'b1;
                        t_we_r[t] <= cpu_we;
                        t_addr_r[t*32 +: 32] <= cpu_addr;
                        t_wdata_r[t*32 +: 32] <= cpu_wdata;
                        t_size_r[t*2 +: 2] <= cpu_size;
                    end else if (wr_go && dst_t == t) begin
                        own_r[t] <= OWN_WR;
                        t_req_r[t] <= 1'b1;
                        t_we_r[t] <= 1'b1;
                        t_addr_r[t*32 +: 32] <= dst_r;
                        t_wdata_r[t*32 +: 32] <= wbuf_r;
                        t_size_r[t*2 +: 2] <= wbn_r[1:0] - 2'h1;
                    end else if (rd_go && src_t == t) begin
                        own_r[t] <= OWN_RD;
                        t_req_r[t] <= 1'b1;
                        t_we_r[t] <= 1'b0;
                        t_addr_r[t*32 +: 32] <= src_r;
                        t_size_r[t*2 +: 2] <= rd_n[1:0] - 2'h1;
                    end
                end else if (t_ack[t]) begin
                    own_r[t] <= OWN_NONE;
                    t_req_r[t] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // transfer engine
    // ****************************************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= S_IDLE;
            ch_r <= 5'h00;
            td_r <= 7'h00;
            f_r <= 3'h0;
            src_r <= 32'h0000_0000;
            dst_r <= 32'h0000_0000;
            rem_r <= 16'h0000;
            inf_r <= 1'b0;
            bst_r <= 7'h01;
            nxt_r <= 7'h00;
            nxv_r <= 1'b0;
            fl_r <= 6'h00;
            rl_r <= 7'h00;
            wl_r <= 7'h00;
            cur_r <= 7'h00;
            rbuf_r <= 32'h0000_0000;
            rbn_r <= 3'h0;
            rbv_r <= 1'b0;
            wbuf_r <= 32'h0000_0000;
            wbn_r <= 3'h0;
            wbv_r <= 1'b0;
            cx_r <= 1'b0;
        end else begin
            if (st_r != S_IDLE && chn_cancel[ch_r]) begin
                cx_r <= 1'b1;
            end
            case (st_r)
                S_IDLE: begin
                    cx_r <= 1'b0;
                    rbv_r <= 1'b0;
                    wbv_r <= 1'b0;
                    if (gnt_vld) begin
                        ch_r <= gnt_idx;
                        td_r <= chain_r[gnt_idx] ? ctd_r[gnt_idx] :
                            chn_first_td[gnt_idx*7 +: 7];
                        f_r <= 3'h0;
                        st_r <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    // words read fresh here, so earlier rewrites take effect
                    f_r <= f_r + 3'h1;
                    case (f_r)
                        3'h1: src_r <= b_rdata;
                        3'h2: dst_r <= b_rdata;
                        3'h3: begin
                            rem_r <= b_rdata[`HDA_W2_CNT_MSB:0];
                            inf_r <= b_rdata[`HDA_W2_CNT_MSB:0] == 16'h0000;
                            bst_r <= b_rdata[`HDA_W2_BST_LSB +: 7] == 7'h00 ?
                                7'h01 : b_rdata[`HDA_W2_BST_LSB +: 7];
                            nxt_r <= b_rdata[`HDA_W2_NXT_LSB +: 7];
                            nxv_r <= b_rdata[`HDA_W2_NXV];
                        end
                        3'h4: begin
                            fl_r <= b_rdata[5:0];
                            st_r <= cx_r ? S_END : S_BST;
                        end
                        default: ;
                    endcase
                end
                S_BST: begin
                    if (!inf_r && {9'h000, bst_r} > rem_r) begin
                        cur_r <= rem_r[6:0];
                        rl_r <= rem_r[6:0];
                        wl_r <= rem_r[6:0];
                    end else begin
                        cur_r <= bst_r;
                        rl_r <= bst_r;
                        wl_r <= bst_r;
                    end
                    st_r <= cx_r ? S_END : S_RUN;
                end
                S_RUN: begin
                    if (rd_dn) begin
                        rbuf_r <= rd_data;
                        rbn_r <= rd_n;
                        rbv_r <= 1'b1;
                        rl_r <= rl_r - {4'h0, rd_n};
                        if (fl_r[`HDA_W3_SINC]) begin
                            src_r <= src_r + {29'h0000_0000, rd_n};
                        end
                    end
                    if (wr_dn) begin
                        wbv_r <= 1'b0;
                        wl_r <= wl_r - {4'h0, wbn_r};
                        if (fl_r[`HDA_W3_DINC]) begin
                            dst_r <= dst_r + {29'h0000_0000, wbn_r};
                        end
                    end
                    // second buffer lets the next read overlap this write
                    if (rbv_r && !wbv_r) begin
                        wbuf_r <= rbuf_r;
                        wbn_r <= rbn_r;
                        wbv_r <= 1'b1;
                        rbv_r <= 1'b0;
                    end
                    if (cx_r && !dma_out) begin
                        st_r <= S_END;
                    end else if (wl_r == 7'h00 && !dma_out) begin
                        if (inf_r || rem_r != {9'h000, cur_r}) begin
                            if (!inf_r) begin
                                rem_r <= rem_r - {9'h000, cur_r};
                            end
                            st_r <= S_BST;
                        end else begin
                            st_r <= S_END;
                        end
                    end
                end
                S_END: st_r <= S_IDLE;
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // channel triggers, chaining and interrupts
    // ****************************************************************
    always @* begin
        for (g = 0; g < NCH; g = g + 1) begin
            trig[g] = chn_hw_trig[g] | chn_cpu_trig[g] |
                (chn_chain_en[g] && fin_v &&
                chn_chain_sel[g*5 +: 5] == ch_r);
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_r <= {NCH{1'b0}};
            chain_r <= {NCH{1'b0}};
            chn_irq0_r <= {NCH{1'b0}};
            chn_irq1_r <= {NCH{1'b0}};
            chn_busy_r <= {NCH{1'b0}};
            for (c = 0; c < NCH; c = c + 1) begin
                ctd_r[c] <= 7'h00;
            end
        end else begin
            chn_irq0_r <= {NCH{1'b0}};
            chn_irq1_r <= {NCH{1'b0}};
            if (st_r == S_END) begin
                if (!cx_r) begin
                    chn_irq0_r[ch_r] <= fl_r[`HDA_W3_IRQ0];
                    chn_irq1_r[ch_r] <= fl_r[`HDA_W3_IRQ1];
                end
                if (!cx_r && nxv_r) begin
                    ctd_r[ch_r] <= nxt_r;
                    chain_r[ch_r] <= 1'b1;
                end else begin
                    chain_r[ch_r] <= 1'b0;
                    pend_r[ch_r] <= 1'b0;
                end
            end
            for (c = 0; c < NCH; c = c + 1) begin
                chn_busy_r[c] <= st_r != S_IDLE && ch_r == c[4:0];
                if (chn_cancel[c] && !(st_r != S_IDLE && ch_r == c[4:0])) begin
                    pend_r[c] <= 1'b0;
                end
                // a trigger landing on a clear still counts
                if (trig[c]) begin
                    pend_r[c] <= 1'b1;
                end
            end
        end
    end

    hda_arb #(
        .NCH(NCH)
    ) u_arb (
        .clk(clk),
        .resetn(resetn),
        .req(pend_r & ~chn_stall),
        .prio(chn_prio),
        .no_rr(chn_no_rr),
        .fair_en(fair_en),
        .take(st_r == S_IDLE && gnt_vld),
        .gnt_vld(gnt_vld),
        .gnt_idx(gnt_idx)
    );

    hda_tdram u_tdram (
        .clk(clk),
        .a_en(t_req_r[8] & ~ram_ack_r),
        .a_we(t_we_r[8]),
        .a_size(t_size_r[17:16]),
        .a_addr(t_addr_r[8*32+10:8*32+2]),
        .a_wdata(t_wdata_r[8*32 +: 32]),
        .a_rdata(ram_rdata),
        .b_addr({td_r, f_r[1:0]}),
        .b_rdata(b_rdata)
    );
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
// ****
// bench
// ****
logic clk = 0, resetn = 0, cpu_req = 0, cpu_we = 0, cpu_done_r;
logic [31:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata_r, dst0, wd0, got;
logic [1:0] cpu_size = 2'h3;
logic slow = 0, seen;
logic [23:0] stall = 0, cancel = 0, trig = 0, hwt = 0, irq0, irq1, busy;
logic [71:0] prio = 0;
logic [167:0] ftd = {24{7'h01}};
logic [119:0] csel = 0;
logic [7:0] spk_req, spk_we, spk_ack;
logic [255:0] spk_addr, spk_wdata, spk_rdata;
logic [15:0] spk_size;
int error_cnt = 0, cmp_count = 0, cyc = 0, wbytes = 0;
typedef struct {logic we; logic [31:0] a; logic [31:0] d;} hda_row_t;
hda_row_t rows [9] = '{'{1'h1, 32'h0200_0010, 32'h0000_0100},
    '{1'h1, 32'h0200_0014, 32'h0100_0200},
    '{1'h1, 32'h0200_0018, 32'h0004_0008},
    '{1'h1, 32'h0200_001C, 32'h0000_003F},
    '{1'h0, 32'h0200_0010, 32'h0000_0100},
    '{1'h0, 32'h0200_0014, 32'h0100_0200},
    '{1'h0, 32'h0200_0018, 32'h0004_0008},
    '{1'h0, 32'h0200_001C, 32'h0000_003F},
    '{1'h0, 32'h0400_0010, 32'hA1A5_0010}};
hda_top i_hda_top (.clk(clk), .resetn(resetn), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_size(cpu_size), .cpu_rdata_r(cpu_rdata_r),
    .cpu_done_r(cpu_done_r), .fair_en(1'h0), .chn_prio(prio),
    .chn_first_td(ftd), .chn_no_rr(24'h0), .chn_hw_trig(hwt),
    .chn_cpu_trig(trig), .chn_chain_en(24'h0), .chn_chain_sel(csel),
    .chn_stall(stall), .chn_cancel(cancel), .chn_irq0_r(irq0),
    .chn_irq1_r(irq1), .chn_busy_r(busy), .spk_req(spk_req),
    .spk_we(spk_we), .spk_addr(spk_addr), .spk_wdata(spk_wdata),
    .spk_size(spk_size), .spk_rdata(spk_rdata), .spk_ack(spk_ack));
hda_spoke_model i_hda_spoke_model (.clk(clk), .resetn(resetn),
    .slow(slow), .spk_req(spk_req), .spk_addr(spk_addr),
    .spk_rdata(spk_rdata), .spk_ack(spk_ack));
always #10 clk = ~clk;
always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
        error_cnt++;
        results();
    end
    if (spk_req[1] === 1'h1 && spk_ack[1] === 1'h1 && spk_we[1] === 1'h1) begin
        if (wbytes == 0) begin
            dst0 = spk_addr[63:32];
            wd0 = spk_wdata[63:32];
        end
        wbytes += spk_size[3:2] + 1;
    end
end
task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
        error_cnt++;
        $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
endtask
task cpu_acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cpu_req <= 1'h1;
    cpu_we <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    do begin
        @(negedge clk);
        n++;
    end while (cpu_done_r !== 1'h1 && n < 50);
    got = cpu_rdata_r;
    chk(cpu_done_r, 32'h1);
    @(posedge clk);
    cpu_req <= 1'h0;
endtask
task fire(input logic hw);
    wbytes = 0;
    @(posedge clk);
    if (hw) hwt <= 24'h1;
    else trig <= 24'h1;
    @(posedge clk);
    trig <= 24'h0;
    hwt <= 24'h0;
endtask
task run(input int n);
    seen = 1'h0;
    repeat (n) begin
        @(negedge clk);
        if (irq0[0] === 1'h1 && irq1[0] === 1'h1) seen = 1'h1;
    end
endtask
task results;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
initial begin
    repeat (5) @(posedge clk);
    chk({busy, spk_req}, 32'h0);
    resetn <= 1'h1;
    foreach (rows[i]) begin
        cpu_acc(rows[i].we, rows[i].a, rows[i].d);
        if (!rows[i].we) chk(got, rows[i].d);
    end
    cpu_acc(1'h1, 32'h0200_0100, 32'h1122_3344);
    cpu_size <= 2'h0;
    cpu_acc(1'h1, 32'h0200_0100, 32'hFFFF_FF55);
    cpu_size <= 2'h3;
    cpu_acc(1'h0, 32'h0200_0100, 32'h0000_0000);
    chk(got, 32'h1122_3355);
    fire(1'h0);
    run(200);
    chk(seen, 32'h1);
    chk(wbytes, 32'h8);
    chk(dst0, 32'h0100_0200);
    chk(wd0, 32'hA5A5_0100);
    slow = 1'h1;
    @(posedge clk);
    stall <= 24'h1;
    fire(1'h1);
    run(40);
    chk(seen | wbytes, 32'h0);
    @(posedge clk);
    stall <= 24'h0;
    run(400);
    chk(seen, 32'h1);
    chk(wbytes, 32'h8);
    fire(1'h0);
    repeat (8) @(posedge clk);
    cancel <= 24'h1;
    @(posedge clk);
    cancel <= 24'h0;
    run(150);
    chk({seen, busy}, 32'h0);
    cpu_acc(1'h1, 32'h0200_0018, 32'h4084_0008);
    fire(1'h0);
    run(300);
    chk(wbytes >= 24, 32'h1);
    cpu_acc(1'h1, 32'h0200_0018, 32'h0004_0008);
    run(300);
    chk(busy, 32'h0);
    results();
end
endmodule
bind hda_top hda_checker #(.NCH(NCH)) i_hda_checker (.clk(clk),
    .resetn(resetn), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
    .cpu_done_r(cpu_done_r), .chn_irq0_r(chn_irq0_r),
    .chn_busy_r(chn_busy_r), .spk_req(spk_req), .spk_addr(spk_addr),
    .spk_ack(spk_ack));
